// file: dv/pmct_core_timing_monitor.sv
// Port-level checker for the core timing sequencer
`timescale 1ns/1ps
module pmct_core_timing_monitor #(
    parameter int unsigned NUM_BP = pmct_pkg::NUM_BP
) (
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    input wire logic                 ins_valid,
    input wire pmct_pkg::pmct_ins_s  ins,
    input wire logic                 ins_ready,
    input wire logic                 ret_valid,
    input wire pmct_pkg::pmct_done_s ret,
    input wire logic                 dbg_halt_req,
    input wire logic                 dbg_run_req,
    input wire logic                 dbg_step_req,
    input wire logic                 dbg_prog_req,
    input wire logic                 dbg_halted,
    input wire logic                 dbg_prog_grant
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Busy clocks while running; halted drain is not counted
    logic [3:0] stall_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stall_r <= 4'h0;
        end else begin
            stall_r <= (ins_ready || dbg_halted) ? 4'h0 : stall_r + 4'h1;
        end
    end
    a_ret_in_range: assert property (
        ret_valid |-> ret.cycles inside {[4'h1:4'h8]})
        else $error("retired clock count out of range");
    a_stall_bound: assert property (stall_r <= 4'h7)
        else $error("core busy beyond eight clocks");
    a_one_clock_path: assert property (
        ret_valid && ret.cycles == 4'h1 |->
        $past(ins_valid && ins_ready) && ret.pc == $past(ins.pc))
        else $error("single clock retire without matching accept");
    a_busy_before_ret: assert property (
        ret_valid && ret.cycles > 4'h1 |-> !$past(ins_ready))
        else $error("ready high while clocks were owed");
    a_ret_holds: assert property (!ret_valid |-> $stable(ret))
        else $error("retire record changed without a finish");
    a_halt_at_boundary: assert property (
        dbg_halt_req && ins_ready && !dbg_halted |=> dbg_halted)
        else $error("halt not taken at boundary");
    a_halt_holds: assert property (
        dbg_halted && !dbg_run_req && !dbg_step_req |=>
        dbg_halted && !ins_ready)
        else $error("halt left without run or step");
    a_grant_follows: assert property (
        dbg_halted && dbg_prog_req && !dbg_run_req && !dbg_step_req
        |=> dbg_prog_grant ##0 !dbg_prog_req [*1] |=> !dbg_prog_grant)
        else $error("programming grant wrong");
    c_divide: cover property (ret_valid && ret.cycles == 4'h8);
    c_grant: cover property (dbg_halted && dbg_prog_grant);
    c_halt: cover property ($rose(dbg_halted));
endmodule : pmct_core_timing_monitor

bind pmct_core_timing pmct_core_timing_monitor #(.NUM_BP(NUM_BP)) u_mon (
    .sys_clk(sys_clk), .rst_n(rst_n), .ins_valid(ins_valid), .ins(ins),
    .ins_ready(ins_ready), .ret_valid(ret_valid), .ret(ret),
    .dbg_halt_req(dbg_halt_req), .dbg_run_req(dbg_run_req),
    .dbg_step_req(dbg_step_req), .dbg_prog_req(dbg_prog_req),
    .dbg_halted(dbg_halted), .dbg_prog_grant(dbg_prog_grant));

// file: dv/pmct_fetch_model.sv
// Fetch-side model offering one opcode at a time to the core
`timescale 1ns/1ps
module pmct_fetch_model (
    input  wire logic          sys_clk,
    input  wire logic          ins_ready,
    output logic               ins_valid,
    output pmct_pkg::pmct_ins_s ins
);
    initial begin
        ins_valid = 1'b0;
        ins       = '0;
    end
    // Hold the offer until ready is seen, release after that edge
    task automatic offer(input logic [7:0] op, input logic [15:0] pc,
                         input logic tk, output bit ok);
        ok = 1'b0;
        @(posedge sys_clk);
        ins_valid <= 1'b1;
        ins       <= '{opcode: op, pc: pc, taken: tk};
        for (int n = 0; n < 40 && !ok; n++) begin
            @(negedge sys_clk);
            ok = (ins_ready === 1'b1);
        end
        @(posedge sys_clk);
        ins_valid <= 1'b0;
        ins       <= ~ins; // Released lines must not keep the old value
    endtask : offer
endmodule : pmct_fetch_model

// file: dv/tb_pipelined_mcu_core_timing.sv
// Self-checking bench for the core timing sequencer
`timescale 1ns/1ps
module tb_pipelined_mcu_core_timing;
    logic                 sys_clk, rst_n, ins_valid, ins_ready, ret_valid;
    pmct_pkg::pmct_ins_s  ins;
    pmct_pkg::pmct_done_s ret;
    logic                 halt_q, run_q, step_q, bp_wr, bp_en, prog_q;
    logic                 halted, grant;
    logic [1:0]           bp_idx;
    logic [15:0]          bp_addr;
    int                   failures, check_count;
    pmct_core_timing #(.NUM_BP(pmct_pkg::NUM_BP)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .ins_valid(ins_valid), .ins(ins),
        .ins_ready(ins_ready), .ret_valid(ret_valid), .ret(ret),
        .dbg_halt_req(halt_q), .dbg_run_req(run_q), .dbg_step_req(step_q),
        .dbg_bp_wr(bp_wr), .dbg_bp_idx(bp_idx), .dbg_bp_addr(bp_addr),
        .dbg_bp_en(bp_en), .dbg_prog_req(prog_q), .dbg_halted(halted),
        .dbg_prog_grant(grant));
    pmct_fetch_model fm (.sys_clk(sys_clk), .ins_ready(ins_ready),
        .ins_valid(ins_valid), .ins(ins));
    always #20 sys_clk = ~sys_clk;
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, exp, input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk
    // Bounded waits; running out ends the run
    task automatic wait_ret(output int n);
        for (n = 1; n <= 20; n++) begin
            @(negedge sys_clk);
            if (ret_valid === 1'b1) return;
        end
        failures++;
        conclude();
    endtask : wait_ret
    task automatic feed(input logic [7:0] op, input logic [15:0] pc,
                        input logic tk);
        bit ok;
        fm.offer(op, pc, tk, ok);
        if (!ok) begin
            failures++;
            conclude();
        end
    endtask : feed
    task automatic run_op(input logic [7:0] op, input logic [15:0] pc,
                          input logic tk, input int by, cy);
        int n;
        feed(op, pc, tk);
        wait_ret(n);
        chk(n, cy, "clocks to retire");
        chk(ret.cycles, cy, "ret cycles");
        chk(ret.bytes, by, "ret bytes");
        chk(ret.pc, pc, "ret pc");
    endtask : run_op
    // One opcode from each timing class, expected figures from the map
    task automatic t_classes;
        logic [7:0] op [11] = '{8'h04, 8'h24, 8'h26, 8'h43, 8'hA4, 8'h84,
                                8'h22, 8'h02, 8'h80, 8'h93, 8'hA5};
        int by [11] = '{1, 2, 1, 3, 1, 1, 1, 3, 2, 1, 1};
        int cy [11] = '{1, 2, 2, 3, 4, 8, 5, 4, 3, 3, 1};
        for (int i = 0; i < 11; i++) begin
            run_op(op[i], 16'h0200 + 16'(i), 1'b0, by[i], cy[i]);
        end
    endtask : t_classes
    task automatic t_branch;
        run_op(8'h60, 16'h0300, 1'b0, 2, 2);
        run_op(8'h60, 16'h0302, 1'b1, 2, 3);
        run_op(8'hD5, 16'h0304, 1'b0, 3, 3);
        run_op(8'hD5, 16'h0307, 1'b1, 3, 4);
    endtask : t_branch
    task automatic pulse_run;
        @(posedge sys_clk) run_q <= 1'b1;
        @(posedge sys_clk) run_q <= 1'b0;
    endtask : pulse_run
    // Halt, grant, single step, resume, then a breakpoint stop
    task automatic t_debug;
        @(posedge sys_clk) halt_q <= 1'b1;
        @(posedge sys_clk) prog_q <= 1'b1;
        halt_q <= 1'b0;
        repeat (2) @(negedge sys_clk);
        chk(ins_ready, 0, "ready while halted");
        chk(grant, 1, "programming grant");
        @(posedge sys_clk) prog_q <= 1'b0;
        fork
            run_op(8'h04, 16'h0400, 1'b0, 1, 1);
            begin
                repeat (2) @(posedge sys_clk);
                step_q <= 1'b1;
                @(posedge sys_clk) step_q <= 1'b0;
            end
        join
        chk(halted, 1, "halted after step");
        chk(grant, 0, "grant dropped with request");
        pulse_run();
        // First fetch after a resume skips breakpoints, so spend it here
        run_op(8'h04, 16'h0410, 1'b0, 1, 1);
        chk(halted, 0, "running after run");
        @(posedge sys_clk) bp_wr <= 1'b1;
        bp_idx  <= 2'h3;
        bp_addr <= 16'h0500;
        bp_en   <= 1'b1;
        @(posedge sys_clk) bp_wr <= 1'b0;
        feed(8'h04, 16'h0500, 1'b0);
        @(negedge sys_clk);
        chk(halted, 1, "breakpoint stop");
        chk(ret.pc, 16'h0410, "no retire at breakpoint");
        pulse_run();
        run_op(8'h04, 16'h0500, 1'b0, 1, 1);
        chk(halted, 0, "running after resume");
    endtask : t_debug
    initial begin
        {sys_clk, rst_n, halt_q, run_q, step_q, bp_wr, bp_en, prog_q} = '0;
        bp_idx      = 2'h0;
        bp_addr     = 16'h0000;
        failures    = 0;
        check_count = 0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_classes();
        t_branch();
        t_debug();
        conclude();
    end
endmodule : tb_pipelined_mcu_core_timing

// file: rtl/pmct_core_timing.sv
// Instruction timing sequencer and debug halt logic of the core
// Function
// - Decode every standard opcode bit-exactly, timing only differs
// - No instruction exceeds eight system clocks
// - 109 instructions spread over nine timing classes
// - Zero to 25 MHz, up to one instruction per clock
// - Most instructions finish in one or two clocks
// - Host breakpoints, run, stop, step
// - Debug uses no program-visible resources
// - Flash programming over the same debug link
// - Clocks equal program bytes for most instructions
// - Untaken conditional branch is one clock shorter
`timescale 1ns/1ps

module pmct_core_timing #(
    parameter int unsigned NUM_BP = pmct_pkg::NUM_BP
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    // Fetch side
    input  wire logic                 ins_valid,
    input  wire pmct_pkg::pmct_ins_s  ins,
    output logic                      ins_ready,
    output logic                      ret_valid,
    output pmct_pkg::pmct_done_s      ret,
    // Debug host side
    input  wire logic                 dbg_halt_req,
    input  wire logic                 dbg_run_req,
    input  wire logic                 dbg_step_req,
    input  wire logic                 dbg_bp_wr,
    input  wire logic [1:0]           dbg_bp_idx,
    input  wire logic [15:0]          dbg_bp_addr,
    input  wire logic                 dbg_bp_en,
    input  wire logic                 dbg_prog_req,
    output logic                      dbg_halted,
    output logic                      dbg_prog_grant
);

    // ------------------------------------------------------------
    // Opcode decode
    // ------------------------------------------------------------
    // Byte length of a standard opcode, column by column
    function automatic logic [1:0] op_len(input logic [7:0] op);
        logic [3:0] hi;
        logic [3:0] lo;
        logic [1:0] n;
        hi = op[7:4];
        lo = op[3:0];
        n  = 2'h1;
        unique case (lo)
            4'h0: n = (hi == 4'h0 || hi >= 4'hE) ? 2'h1 :
                      (hi <= 4'h3 || hi == 4'h9) ? 2'h3 : 2'h2;
            4'h1: n = 2'h2;
            4'h2: n = (hi <= 4'h1) ? 2'h3 :
                      (hi <= 4'h3 || hi >= 4'hE) ? 2'h1 : 2'h2;
            4'h3: n = (hi >= 4'h4 && hi <= 4'h6) ? 2'h3 : 2'h1;
            4'h4: n = (hi == 4'hB) ? 2'h3 :
                      (hi <= 4'h1 || hi >= 4'hC || hi == 4'h8 ||
                       hi == 4'hA) ? 2'h1 : 2'h2;
            4'h5: n = (hi == 4'h7 || hi == 4'h8 || hi == 4'hB ||
                       hi == 4'hD) ? 2'h3 : (hi == 4'hA) ? 2'h1 : 2'h2;
            4'h6, 4'h7: n = (hi == 4'hB) ? 2'h3 :
                      (hi == 4'h7 || hi == 4'h8 || hi == 4'hA) ? 2'h2
                                                                : 2'h1;
            default: n = (hi == 4'hB) ? 2'h3 :
                      (hi == 4'h7 || hi == 4'h8 || hi == 4'hA ||
                       hi == 4'hD) ? 2'h2 : 2'h1;
        endcase
        return n;
    endfunction : op_len

    // Conditional branches: relative jumps on flags, bits, compares
    function automatic logic op_cond(input logic [7:0] op);
        logic [3:0] hi;
        logic [3:0] lo;
        hi = op[7:4];
        lo = op[3:0];
        return (lo == 4'h0 && hi >= 4'h1 && hi <= 4'h7) ||
               (lo == 4'h4 && hi == 4'hB) ||
               (lo == 4'h5 && (hi == 4'hB || hi == 4'hD)) ||
               ((lo == 4'h6 || lo == 4'h7) && hi == 4'hB) ||
               (lo >= 4'h8 && (hi == 4'hB || hi == 4'hD));
    endfunction : op_cond

    wire logic [7:0]  op      = ins.opcode;
    wire logic [1:0]  len     = op_len(op);
    wire logic        cond    = op_cond(op);
    // One-byte and CJNE indirect-register forms spend one extra clock on the address
    wire logic        ind_x   = (op[3:0] == 4'h6 || op[3:0] == 4'h7) &&
                                (len == 2'h1 || op[7:4] == 4'hB);
    // Bytes give the clocks for most opcodes
    wire logic [3:0]  base    = {2'b00, len} + {3'b000, ind_x};
    wire logic        is_ret  = op == 8'h22 || op == 8'h32;
    wire logic        is_long = op == 8'h02 || op == 8'h12;
    wire logic        is_shrt = op[3:0] == 4'h1 || op == 8'h80 ||
                                op == 8'h73;
    wire logic        is_xmem = op == 8'h83 || op == 8'h93 ||
                                ((op[7:4] >= 4'hE) &&
                                 (op[3:0] == 4'h0 || op[3:0] == 4'h2 ||
                                  op[3:0] == 4'h3));
    // Fixed classes override the byte count
    wire logic [3:0]  fixed   =
        (op == 8'h84) ? pmct_pkg::CYC_DIV  :
        (op == 8'hA4) ? pmct_pkg::CYC_MUL  :
        is_ret        ? pmct_pkg::CYC_RET  :
        is_long       ? pmct_pkg::CYC_LONG :
        is_shrt       ? pmct_pkg::CYC_SHORT:
        is_xmem       ? pmct_pkg::CYC_XMEM : base;
    // A taken branch costs one clock more than a fall-through
    wire logic [3:0]  cycles  = fixed +
                                {3'b000, cond & ins.taken};

    // ------------------------------------------------------------
    // Breakpoint comparators, private flops only
    // ------------------------------------------------------------
    logic [15:0]       bp_addr_r [NUM_BP];  // Watched code addresses
    logic [NUM_BP-1:0] bp_en_r;             // Armed comparators
    logic [NUM_BP-1:0] bp_match;            // Per-slot hit

    for (genvar g = 0; g < NUM_BP; g++) begin : g_bp
        assign bp_match[g] = bp_en_r[g] && bp_addr_r[g] == ins.pc;
    end

    // Host writes one slot at a time; nothing here touches user RAM
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bp_en_r <= '0;
            for (int i = 0; i < NUM_BP; i++) begin
                bp_addr_r[i] <= 16'h0000;
            end
        end else if (dbg_bp_wr) begin
            bp_en_r[dbg_bp_idx]   <= dbg_bp_en;
            bp_addr_r[dbg_bp_idx] <= dbg_bp_addr;
        end
    end

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    pmct_pkg::pmct_state_e state_r, state_nxt;  // Run/halt state
    logic [3:0]  cnt_r, cnt_nxt;                // Clocks still owed
    logic        step_r, step_nxt;              // One-shot run
    logic        skip_r, skip_nxt;              // Ignore bp once
    logic        ready_r, ready_nxt;            // Registered ready

    // Boundary means the previous instruction has used its clocks
    wire logic boundary = cnt_r == 4'h0;
    wire logic bp_hit   = |bp_match && !skip_r && ins_valid;
    // Halt only between instructions so state is coherent
    wire logic halt_now = boundary && (dbg_halt_req || bp_hit);
    wire logic accept   = ins_valid && ready_r && !halt_now;
    wire logic finish   = (accept && cycles == 4'h1) ||
                          cnt_r == 4'h1;

    // Next-state decode for run, stop and single step
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = (cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0;
        step_nxt  = step_r;
        skip_nxt  = skip_r;
        unique case (state_r)
            pmct_pkg::PMCT_IDLE, pmct_pkg::PMCT_EXEC: begin
                if (halt_now) begin
                    state_nxt = pmct_pkg::PMCT_HALT;
                end else if (accept) begin
                    cnt_nxt   = cycles - 4'h1;
                    state_nxt = pmct_pkg::PMCT_EXEC;
                    skip_nxt  = 1'b0;
                    // A step stops after exactly one instruction
                    if (step_r) begin
                        step_nxt  = 1'b0;
                        state_nxt = pmct_pkg::PMCT_HALT;
                    end
                end else if (boundary) begin
                    state_nxt = pmct_pkg::PMCT_IDLE;
                end
            end
            pmct_pkg::PMCT_HALT: begin
                // Finish owed clocks of a stepped instruction first
                if (boundary && (dbg_run_req || dbg_step_req)) begin
                    state_nxt = pmct_pkg::PMCT_IDLE;
                    step_nxt  = dbg_step_req && !dbg_run_req;
                    skip_nxt  = 1'b1; // Resume past the hit address
                end
            end
            default: state_nxt = pmct_pkg::PMCT_HALT;
        endcase
        ready_nxt = cnt_nxt == 4'h0 &&
                    state_nxt != pmct_pkg::PMCT_HALT;
    end

    // State flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= pmct_pkg::PMCT_IDLE;
            cnt_r   <= 4'h0;
            step_r  <= 1'b0;
            skip_r  <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            step_r  <= step_nxt;
            skip_r  <= skip_nxt;
            ready_r <= ready_nxt;
        end
    end

    // ------------------------------------------------------------
    // Retire record and debug status outputs
    // ------------------------------------------------------------
    pmct_pkg::pmct_done_s cur_r;  // Instruction in flight

    // Captures the record at accept, shows it in the finish pulse
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_r     <= '0;
            ret       <= '0;
            ret_valid <= 1'b0;
        end else begin
            if (accept) begin
                cur_r <= '{pc: ins.pc, bytes: len, cycles: cycles};
            end
            ret_valid <= finish;
            if (finish) begin
                ret <= (accept && cycles == 4'h1)
                     ? '{pc: ins.pc, bytes: len, cycles: cycles}
                     : cur_r;
            end
        end
    end

    // Programming is granted only while the core is stopped
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dbg_halted     <= 1'b0;
            dbg_prog_grant <= 1'b0;
        end else begin
            dbg_halted     <= state_nxt == pmct_pkg::PMCT_HALT;
            dbg_prog_grant <= dbg_prog_req &&
                              state_nxt == pmct_pkg::PMCT_HALT;
        end
    end

    assign ins_ready = ready_r;

endmodule : pmct_core_timing

// file: rtl/pmct_pkg.sv
// Shared constants and carrier types for the core timing sequencer
package pmct_pkg;

    // ------------------------------------------------------------
    // Clock and throughput
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 25_000_000; // Top system clock
    localparam int unsigned CLK_MHZ     = 25;         // Same rate, in MHz
    localparam int unsigned CLK_NS      = 1000 / CLK_MHZ; // Period, ns
    localparam int unsigned PEAK_MIPS   = 25;         // One per clock
    localparam int unsigned NUM_INSTR   = 109;        // Distinct kinds

    // ------------------------------------------------------------
    // Field widths
    // ------------------------------------------------------------
    localparam int unsigned OP_W   = 8;               // Opcode byte
    localparam int unsigned PC_W   = 16;              // Code address
    localparam int unsigned LEN_W  = 2;               // 1..3 bytes
    localparam int unsigned CYC_W  = 4;               // 1..8 clocks

    // ------------------------------------------------------------
    // Clock counts of the instruction classes
    // ------------------------------------------------------------
    localparam logic [CYC_W-1:0] CYC_MAX     = 4'h8; // Longest of all
    localparam logic [CYC_W-1:0] CYC_MUL     = 4'h4; // Multiply
    localparam logic [CYC_W-1:0] CYC_DIV     = 4'h8; // Divide
    localparam logic [CYC_W-1:0] CYC_RET     = 4'h5; // Return pair
    localparam logic [CYC_W-1:0] CYC_LONG    = 4'h4; // Long jump/call
    localparam logic [CYC_W-1:0] CYC_SHORT   = 4'h3; // Short/abs jumps
    localparam logic [CYC_W-1:0] CYC_XMEM    = 4'h3; // Code/ext moves
    localparam logic [CYC_W-1:0] CYC_ONE     = 4'h1; // Single clock

    // ------------------------------------------------------------
    // Debug resources
    // ------------------------------------------------------------
    localparam int unsigned NUM_BP = 4;               // Breakpoints

    // Sequencer states, Gray coded along idle->exec->halt
    typedef enum logic [1:0] {
        PMCT_IDLE = 2'b00,
        PMCT_EXEC = 2'b01,
        PMCT_HALT = 2'b11
    } pmct_state_e;

    // Instruction offered by the fetch stage
    typedef struct packed {
        logic [OP_W-1:0] opcode;  // First program byte
        logic [PC_W-1:0] pc;      // Its code address
        logic            taken;   // Branch condition result
    } pmct_ins_s;

    // Record of a retired instruction
    typedef struct packed {
        logic [PC_W-1:0]  pc;     // Address of the instruction
        logic [LEN_W-1:0] bytes;  // Program bytes
        logic [CYC_W-1:0] cycles; // Clocks it took
    } pmct_done_s;

endpackage : pmct_pkg
